// ==== shared/lpfc_if.sv ====
// link between the system controller and its requesting peripherals
`timescale 1ns/10ps
interface lpfc_if;
   logic       tim_a_irq;
   logic       tim_b_irq;
   logic       tim_c_irq;
   logic       gpio_req;
   logic       spi_act;
   logic       i2c_act;
   logic       uart_act;
   logic       adc_trig;
   logic       cpu_irq;
   logic       sleep_req;
   logic       deep_sleep_select;
   logic       osc_en;
   logic       osc_base;
   logic       mclk_on_osc;
   logic       cpu_clk_en;
   logic       bus_clk_en;
   logic       lf_clk_en;
   logic       timer_clk_en;
   logic       mid_freq_clock_en;
   logic       fast_active;
   logic [2:0] mode;

   modport dev (
      input  tim_a_irq, tim_b_irq, tim_c_irq, gpio_req, spi_act, i2c_act,
             uart_act, adc_trig, cpu_irq, sleep_req, deep_sleep_select,
      output osc_en, osc_base, mclk_on_osc, cpu_clk_en, bus_clk_en,
             lf_clk_en, timer_clk_en, mid_freq_clock_en, fast_active, mode
   );

   modport per (
      output tim_a_irq, tim_b_irq, tim_c_irq, gpio_req, spi_act, i2c_act,
             uart_act, adc_trig, cpu_irq, sleep_req, deep_sleep_select,
      input  osc_en, osc_base, mclk_on_osc, cpu_clk_en, bus_clk_en,
             lf_clk_en, timer_clk_en, mid_freq_clock_en, fast_active, mode
   );
endinterface

// ==== shared/lpfc_pkg.sv ====
// constants, types and helpers shared by the fast clock request design
package lpfc_pkg;

   // axi4-lite register offsets (byte addresses)
   localparam int          ADDR_W          = 5;
   localparam logic [4:0]  OSC_CFG_ADDR    = 5'h00;
   localparam logic [4:0]  MCLK_CFG_ADDR   = 5'h04;
   localparam logic [4:0]  PMODE_CFG_ADDR  = 5'h08;
   localparam logic [4:0]  PERIPH_CFG_ADDR = 5'h0C;
   localparam logic [4:0]  STATUS_ADDR     = 5'h10;

   // osc_config_reg fields
   localparam int OSC_DISABLE_BIT    = 0;
   localparam int OSC_OFF_STOP_BIT   = 1;
   localparam int GLOBAL_BLOCK_BIT   = 2;
   localparam int IRQ_FAST_WAKE_BIT  = 3;
   localparam int OSC_LOW_FREQ_BIT   = 4;
   localparam logic [4:0] OSC_CFG_RST = 5'h00;

   // main_clock_config_reg fields
   localparam int SLOW_CLK_SEL_BIT   = 0;
   localparam int GATE_STBY_BIT      = 1;
   localparam int MID_FREQ_CLOCK_USE_BIT      = 2;
   localparam logic [2:0] MCLK_CFG_RST = 3'h0;

   // periph_clock_config_reg fields
   localparam int SPI_BLOCK_BIT      = 0;
   localparam int I2C_BLOCK_BIT      = 1;
   localparam int UART_BLOCK_BIT     = 2;
   localparam int TIM_C_MASK_BIT     = 3;
   localparam logic [3:0] PERIPH_CFG_RST = 4'h0;

   // deep_sleep_level_config encodings
   localparam logic [1:0] DSL_STOP     = 2'b00;
   localparam logic [1:0] DSL_STANDBY  = 2'b01;
   localparam logic [1:0] DSL_SHUTDOWN = 2'b10;
   localparam logic [1:0] PMODE_CFG_RST = 2'b00;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // hold period in system oscillator cycles, oscillator tick from core
   localparam int         CORE_MHZ     = 100;
   localparam int         OSC_BASE_MHZ = 24;
   localparam int         ACC_W        = 7;
   localparam logic [6:0] ACC_STEP     = 7'(OSC_BASE_MHZ);
   localparam logic [6:0] ACC_WRAP     = 7'(CORE_MHZ);
   localparam int         HOLD_W       = 6;
   localparam logic [5:0] HOLD_OSC_CYCLES = 6'd41;

   // synchronised request vector positions
   localparam int NUM_REQ  = 9;
   localparam int RQ_TIM_A = 0;
   localparam int RQ_TIM_B = 1;
   localparam int RQ_TIM_C = 2;
   localparam int RQ_GPIO  = 3;
   localparam int RQ_SPI   = 4;
   localparam int RQ_I2C   = 5;
   localparam int RQ_UART  = 6;
   localparam int RQ_ADC   = 7;
   localparam int RQ_IRQ   = 8;

   typedef enum logic [2:0] {
      MODE_RUN      = 3'b000,
      MODE_SLEEP    = 3'b001,
      MODE_STOP     = 3'b011,
      MODE_STANDBY  = 3'b010,
      MODE_SHUTDOWN = 3'b110
   } mode_t;

   function automatic logic is_deep(input mode_t m);
      is_deep = (m == MODE_STOP) || (m == MODE_STANDBY) ||
                (m == MODE_SHUTDOWN);
   endfunction

endpackage

// ==== test/low_power_entry_fast_clock_request_bench.sv ====
// self-checking bench joining both ends of the fast clock link
`timescale 1ns/10ps
module low_power_entry_fast_clock_request_bench
   import lpfc_pkg::*;
;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [31:0] awaddr, wdata, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready, dsel, wait_for_interrupt_instr;
   logic [8:0]  rq;
   wire  [31:0] rdata;
   wire  [1:0]  bresp, rresp;
   wire         awready, wready, bvalid, arready, rvalid;
   int          miscompares = 0;
   int          n_checks = 0;
   always #5 core_clk_i = ~core_clk_i;
   lpfc_if lk ();
   lpfc_system_controller_end lpfc_system_controller_end_i (.core_clk_i, .rst_i, .link(lk),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready));
   lpfc_periph_end lpfc_periph_end_i (.core_clk_i, .rst_i, .link(lk),
      .tim_a_irq_i(rq[RQ_TIM_A]), .tim_b_irq_i(rq[RQ_TIM_B]),
      .tim_c_irq_i(rq[RQ_TIM_C]), .gpio_event_i(rq[RQ_GPIO]),
      .gpio_req_en_i(1'b1), .spi_act_i(rq[RQ_SPI]),
      .i2c_act_i(rq[RQ_I2C]), .uart_act_i(rq[RQ_UART]),
      .adc_trig_i(rq[RQ_ADC]), .cpu_irq_i(rq[RQ_IRQ]),
      .deep_sleep_select_i(dsel), .wfi_i(wait_for_interrupt_instr), .fast_active_o(),
      .cpu_clk_en_o(), .mode_o());
   lpfc_asserts lpfc_asserts_i (.core_clk_i, .rst_i,
      .spi_act(lk.spi_act), .i2c_act(lk.i2c_act),
      .uart_act(lk.uart_act), .adc_trig(lk.adc_trig),
      .cpu_irq(lk.cpu_irq), .sleep_req(lk.sleep_req),
      .deep_sleep_select(lk.deep_sleep_select), .osc_en(lk.osc_en),
      .osc_base(lk.osc_base), .mclk_on_osc(lk.mclk_on_osc),
      .cpu_clk_en(lk.cpu_clk_en), .bus_clk_en(lk.bus_clk_en),
      .fast_active(lk.fast_active), .mode(lk.mode));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic hang();
      chk(32'h0000_0000, 32'h0000_0001);
      report_and_stop();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task automatic axw(input logic [4:0] a, input logic [31:0] d,
                      input logic [1:0] e);
      int i;
      @(posedge core_clk_i);
      awaddr <= 32'(a);
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50 && bvalid !== 1'b1; i++) begin
         @(posedge core_clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (i == 50) hang();
      chk(bresp, e);
   endtask
   task automatic axr(input logic [4:0] a, output logic [31:0] d);
      int i;
      @(posedge core_clk_i);
      araddr <= 32'(a);
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50 && rvalid !== 1'b1; i++) begin
         @(posedge core_clk_i);
         if (arready) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (i == 50) hang();
      d = rdata;
   endtask
   // raise one source, judge acceptance, drop it and wait out the hold
   task automatic pulse(input int s, input logic e);
      int c;
      rq[s] <= 1'b1;
      cyc(12);
      chk(lk.fast_active, e);
      if (e) chk(lk.mclk_on_osc, 1'b1);
      rq[s] <= 1'b0;
      for (c = 0; c < 300 && lk.fast_active === 1'b1; c++) cyc(1);
      if (c == 300) hang();
      if (e) chk(c > 160, 1'b1);
      cyc(1);
   endtask
   task automatic t_regs();
      logic [31:0] d;
      axr(STATUS_ADDR, d);
      chk(d, 32'h0000_0070);
      pulse(RQ_SPI, 1'b0);
      axw(5'h14, 32'h0000_0001, RESP_SLVERR);
      axw(MCLK_CFG_ADDR, 32'h0000_0001, RESP_OKAY);
      cyc(3);
      chk(lk.mclk_on_osc, 1'b0);
      $display("regs done");
   endtask
   task automatic t_serial();
      for (int i = 0; i < 3; i++) begin
         axw(PERIPH_CFG_ADDR, 32'(1 << i), RESP_OKAY);
         pulse(RQ_SPI + i, 1'b0);
         axw(PERIPH_CFG_ADDR, 32'h0000_0000, RESP_OKAY);
         pulse(RQ_SPI + i, 1'b1);
         chk(lk.mclk_on_osc, 1'b0);
      end
      $display("serial done");
   endtask
   task automatic t_block();
      axw(OSC_CFG_ADDR, 32'h0000_0004, RESP_OKAY);
      pulse(RQ_UART, 1'b0);
      axw(OSC_CFG_ADDR, 32'h0000_0000, RESP_OKAY);
      pulse(RQ_IRQ, 1'b0);
      axw(OSC_CFG_ADDR, 32'h0000_0008, RESP_OKAY);
      pulse(RQ_IRQ, 1'b1);
      axw(OSC_CFG_ADDR, 32'h0000_0000, RESP_OKAY);
      $display("block done");
   endtask
   task automatic t_adc();
      pulse(RQ_ADC, 1'b0);
      axw(OSC_CFG_ADDR, 32'h0000_0001, RESP_OKAY);
      cyc(3);
      chk(lk.osc_en, 1'b0);
      pulse(RQ_ADC, 1'b1);
      chk(lk.osc_en, 1'b0);
      axw(OSC_CFG_ADDR, 32'h0000_0000, RESP_OKAY);
      $display("adc done");
   endtask
   task automatic t_modes();
      mode_t m [4];
      m = '{MODE_SLEEP, MODE_STOP, MODE_STANDBY, MODE_SHUTDOWN};
      for (int i = 0; i < 4; i++) begin
         if (i > 0) axw(PMODE_CFG_ADDR, 32'(i - 1), RESP_OKAY);
         dsel <= (i > 0);
         cyc(1);
         wait_for_interrupt_instr <= 1'b1;
         cyc(1);
         wait_for_interrupt_instr <= 1'b0;
         cyc(6);
         chk(lk.mode, m[i]);
         chk(lk.cpu_clk_en, 1'b0);
         if (i == 1) pulse(RQ_SPI, 1'b1);
         pulse(RQ_IRQ, 1'b0);
         chk(lk.mode, i == 3 ? MODE_SHUTDOWN : MODE_RUN);
      end
      rst_i <= 1'b1;
      cyc(2);
      rst_i <= 1'b0;
      cyc(2);
      chk(lk.mode, MODE_RUN);
      $display("modes done");
   endtask
   task automatic t_gated();
      axw(MCLK_CFG_ADDR, 32'h0000_0006, RESP_OKAY);
      axw(PMODE_CFG_ADDR, 32'h0000_0001, RESP_OKAY);
      wait_for_interrupt_instr <= 1'b1;
      cyc(1);
      wait_for_interrupt_instr <= 1'b0;
      cyc(6);
      chk({lk.bus_clk_en, lk.lf_clk_en, lk.timer_clk_en, lk.mid_freq_clock_en},
          32'h0000_0002);
      pulse(RQ_IRQ, 1'b0);
      chk(lk.mid_freq_clock_en, 1'b1);
      $display("gated done");
   endtask
   initial begin
      {awaddr, wdata, araddr} = '0;
      {awvalid, wvalid, bready, arvalid, rready, dsel, wait_for_interrupt_instr} = '0;
      rq = '0;
      cyc(12);
      rst_i <= 1'b0;
      t_regs();
      t_serial();
      t_block();
      t_adc();
      t_modes();
      t_gated();
      report_and_stop();
   end
endmodule

// ==== test/lpfc_asserts.sv ====
// concurrent checks on the fast clock request link
`timescale 1ns/10ps
module lpfc_asserts
   import lpfc_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic       spi_act,
   input wire logic       i2c_act,
   input wire logic       uart_act,
   input wire logic       adc_trig,
   input wire logic       cpu_irq,
   input wire logic       sleep_req,
   input wire logic       deep_sleep_select,
   input wire logic       osc_en,
   input wire logic       osc_base,
   input wire logic       mclk_on_osc,
   input wire logic       cpu_clk_en,
   input wire logic       bus_clk_en,
   input wire logic       fast_active,
   input wire logic [2:0] mode
);
   // cycles since any raw spi, i2c, uart, adc or irq request, saturates so it never wraps
   logic [7:0] idle_ff;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i)
         idle_ff <= 8'h00;
      else if (spi_act | i2c_act | uart_act | adc_trig | cpu_irq)
         idle_ff <= 8'h00;
      else if (idle_ff != 8'hFF)
         idle_ff <= idle_ff + 8'h01;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   a_cpu_clk_run: assert property (cpu_clk_en == (mode == MODE_RUN))
      else $error("cpu clock enable disagrees with mode");
   a_sleep_bus: assert property (mode == MODE_SLEEP |-> bus_clk_en)
      else $error("bus clock off in sleep");
   a_fast_tree: assert property (fast_active |->
      osc_en && osc_base && mclk_on_osc && bus_clk_en)
      else $error("forced clock tree not applied");
   a_sleep_entry: assert property (sleep_req && !deep_sleep_select &&
      mode == MODE_RUN |-> ##[1:3] mode == MODE_SLEEP)
      else $error("sleep not entered");
   a_deep_entry: assert property (sleep_req && deep_sleep_select &&
      mode == MODE_RUN |-> ##[1:3] mode[1])
      else $error("deep sleep not entered");
   a_shutdown_kept: assert property (mode == MODE_SHUTDOWN |=>
      mode == MODE_SHUTDOWN)
      else $error("shutdown left without reset");
   a_fast_cause: assert property ($rose(fast_active) |->
      idle_ff <= 8'h08)
      else $error("fast clock without request");
   a_hold_len: assert property ($fell(fast_active) |->
      idle_ff >= 8'hA6 && idle_ff <= 8'hBA)
      else $error("hold period length wrong");
endmodule

// ==== verilog/lpfc_hold_timer.sv ====
// hold period counter on a fractional system oscillator tick
`timescale 1ns/10ps
module lpfc_hold_timer
   import lpfc_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic clear_i,
   output logic      done_o
);
   logic [ACC_W-1:0]  acc_ff;
   logic [ACC_W-1:0]  nxt_acc;
   logic              osc_tick;
   logic [HOLD_W-1:0] cnt_ff;

   // 24 ticks per 100 core cycles, no exact integer divider exists
   always_comb begin
      nxt_acc  = acc_ff + ACC_STEP;
      osc_tick = 1'b0;
      if (nxt_acc >= ACC_WRAP) begin
         nxt_acc  = nxt_acc - ACC_WRAP;
         osc_tick = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
      end else if (clear_i) begin
         cnt_ff <= '0;
      end else if (osc_tick && cnt_ff != HOLD_OSC_CYCLES) begin
         cnt_ff <= cnt_ff + 6'd1;
      end
   end

   assign done_o = (cnt_ff == HOLD_OSC_CYCLES) && !clear_i;
endmodule

// ==== verilog/lpfc_periph_end.sv ====
// requesting peripherals and cpu sleep side of the fast clock link
`timescale 1ns/10ps
module lpfc_periph_end
   import lpfc_pkg::*;
(
   input  wire logic   core_clk_i,
   input  wire logic   rst_i,
   lpfc_if.per         link,
   input  wire logic   tim_a_irq_i,
   input  wire logic   tim_b_irq_i,
   input  wire logic   tim_c_irq_i,
   input  wire logic   gpio_event_i,
   input  wire logic   gpio_req_en_i,
   input  wire logic   spi_act_i,
   input  wire logic   i2c_act_i,
   input  wire logic   uart_act_i,
   input  wire logic   adc_trig_i,
   input  wire logic   cpu_irq_i,
   input  wire logic   deep_sleep_select_i,
   input  wire logic   wfi_i,
   output logic        fast_active_o,
   output logic        cpu_clk_en_o,
   output logic [2:0]  mode_o
);
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         link.tim_a_irq <= 1'b0;
         link.tim_b_irq <= 1'b0;
         link.tim_c_irq <= 1'b0;
         link.gpio_req  <= 1'b0;
         link.spi_act   <= 1'b0;
         link.i2c_act   <= 1'b0;
         link.uart_act  <= 1'b0;
         link.adc_trig  <= 1'b0;
         link.cpu_irq   <= 1'b0;
      end else begin
         link.tim_a_irq <= tim_a_irq_i;
         link.tim_b_irq <= tim_b_irq_i;
         link.tim_c_irq <= tim_c_irq_i;
         link.gpio_req  <= gpio_event_i & gpio_req_en_i;
         link.spi_act   <= spi_act_i;
         link.i2c_act   <= i2c_act_i;
         link.uart_act  <= uart_act_i;
         link.adc_trig  <= adc_trig_i;
         link.cpu_irq   <= cpu_irq_i;
      end
   end

   // sleep entry: select bit held, instruction gives one pulse
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         link.sleep_req         <= 1'b0;
         link.deep_sleep_select <= 1'b0;
      end else begin
         link.sleep_req         <= wfi_i;
         link.deep_sleep_select <= deep_sleep_select_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fast_active_o <= 1'b0;
         cpu_clk_en_o  <= 1'b0;
         mode_o        <= MODE_RUN;
      end else begin
         fast_active_o <= link.fast_active;
         cpu_clk_en_o  <= link.cpu_clk_en;
         mode_o        <= link.mode;
      end
   end
endmodule

// ==== verilog/lpfc_system_controller_end.sv ====
// system controller: low-power mode entry and fast clock requests
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
module lpfc_system_controller_end
   import lpfc_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   lpfc_if.dev              link,
   input  wire logic [31:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [31:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i
);
   logic [4:0]         osc_cfg_ff;
   logic [2:0]         mclk_cfg_ff;
   logic [1:0]         pmode_cfg_ff;
   logic [3:0]         periph_cfg_ff;
   logic               aw_got_ff;
   logic               w_got_ff;
   logic [ADDR_W-1:0]  awaddr_ff;
   logic [31:0]        wdata_ff;
   logic               wstrb0_ff;
   logic               do_wr;
   logic [NUM_REQ-1:0] req_s1_ff;
   logic [NUM_REQ-1:0] req_s2_ff;
   logic [NUM_REQ-1:0] raw_req;
   mode_t              mode_ff;
   mode_t              nxt_mode;
   logic               osc_off_stop_act_ff;
   logic               gate_stby_act_ff;
   logic               low_freq_act_ff;
   logic               fast_active_ff;
   logic               cfg_changed_ff;
   logic               req_any;
   logic               on_base;
   logic               accept;
   logic               hold_done;
   logic               gated_stby;
   logic               cfg_wr;

   function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a,
                                            input logic [15:0] st);
      case (a)
         OSC_CFG_ADDR:    read_mux = {27'h0, osc_cfg_ff};
         MCLK_CFG_ADDR:   read_mux = {29'h0, mclk_cfg_ff};
         PMODE_CFG_ADDR:  read_mux = {30'h0, pmode_cfg_ff};
         PERIPH_CFG_ADDR: read_mux = {28'h0, periph_cfg_ff};
         STATUS_ADDR:     read_mux = {16'h0, st};
         default:         read_mux = 32'h0000_0000;
      endcase
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == OSC_CFG_ADDR) || (a == MCLK_CFG_ADDR) ||
               (a == PMODE_CFG_ADDR) || (a == PERIPH_CFG_ADDR) ||
               (a == STATUS_ADDR);
   endfunction

   // axi write channel: address and data taken in either order
   assign do_wr = aw_got_ff && w_got_ff && !s_axi_bvalid_o;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= RESP_OKAY;
         aw_got_ff       <= 1'b0;
         w_got_ff        <= 1'b0;
         awaddr_ff       <= '0;
         wdata_ff        <= 32'h0000_0000;
         wstrb0_ff       <= 1'b0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_ff       <= 1'b1;
            awaddr_ff       <= s_axi_awaddr_i[ADDR_W-1:0];
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_ff       <= 1'b1;
            wdata_ff       <= s_axi_wdata_i;
            wstrb0_ff      <= s_axi_wstrb_i[0];
            s_axi_wready_o <= 1'b0;
         end
         if (do_wr) begin
            aw_got_ff      <= 1'b0;
            w_got_ff       <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            // status is read only, writes to it are refused
            s_axi_bresp_o  <= (mapped(awaddr_ff) &&
                               awaddr_ff != STATUS_ADDR) ?
                              RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end

   // axi read channel, answer one cycle after the address
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rdata_o   <= read_mux(s_axi_araddr_i[ADDR_W-1:0],
                               {5'h0, cfg_changed_ff, req_any,
                                fast_active_ff, link.mid_freq_clock_en,
                                link.mclk_on_osc, link.osc_base,
                                link.osc_en, 1'b0, mode_ff});
         s_axi_rresp_o   <= mapped(s_axi_araddr_i[ADDR_W-1:0]) ?
                            RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o  <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // configuration registers, only the low byte lane carries fields
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         osc_cfg_ff    <= OSC_CFG_RST;
         mclk_cfg_ff   <= MCLK_CFG_RST;
         pmode_cfg_ff  <= PMODE_CFG_RST;
         periph_cfg_ff <= PERIPH_CFG_RST;
      end else if (do_wr && wstrb0_ff) begin
         case (awaddr_ff)
            OSC_CFG_ADDR:    osc_cfg_ff    <= wdata_ff[4:0];
            MCLK_CFG_ADDR:   mclk_cfg_ff   <= wdata_ff[2:0];
            PMODE_CFG_ADDR:  pmode_cfg_ff  <= wdata_ff[1:0];
            PERIPH_CFG_ADDR: periph_cfg_ff <= wdata_ff[3:0];
            default: ;
         endcase
      end
   end

   // peripheral requests arrive asynchronously
   assign raw_req = {link.cpu_irq, link.adc_trig, link.uart_act,
                     link.i2c_act, link.spi_act, link.gpio_req,
                     link.tim_c_irq, link.tim_b_irq, link.tim_a_irq};

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_s1_ff <= '0;
         req_s2_ff <= '0;
      end else begin
         req_s1_ff <= raw_req;
         req_s2_ff <= req_s1_ff;
      end
   end

   assign gated_stby = (mode_ff == MODE_STANDBY) && gate_stby_act_ff;

   always_comb begin
      req_any = req_s2_ff[RQ_GPIO] |
         (req_s2_ff[RQ_SPI]  & !periph_cfg_ff[SPI_BLOCK_BIT]) |
         (req_s2_ff[RQ_I2C]  & !periph_cfg_ff[I2C_BLOCK_BIT]) |
         (req_s2_ff[RQ_UART] & !periph_cfg_ff[UART_BLOCK_BIT]) |
         (req_s2_ff[RQ_ADC]  & (!link.osc_en | fast_active_ff)) |
         (req_s2_ff[RQ_IRQ]  & osc_cfg_ff[IRQ_FAST_WAKE_BIT]) |
         (gated_stby & (req_s2_ff[RQ_TIM_A] | req_s2_ff[RQ_TIM_B])) |
         (gated_stby & req_s2_ff[RQ_TIM_C] &
          periph_cfg_ff[TIM_C_MASK_BIT]);
      if (osc_cfg_ff[GLOBAL_BLOCK_BIT]) begin
         req_any = 1'b0;
      end
   end

   // already on oscillator at base rate: request would change nothing
   assign on_base = link.mclk_on_osc && link.osc_en && link.osc_base;
   assign accept  = req_any && !fast_active_ff && !on_base;
   assign cfg_wr  = do_wr && wstrb0_ff && (awaddr_ff == OSC_CFG_ADDR ||
                    awaddr_ff == MCLK_CFG_ADDR);

   lpfc_hold_timer u_hold (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .clear_i    (!fast_active_ff || req_any),
      .done_o     (hold_done)
   );

   // forced config is an overlay on the registers, so dropping it
   // restores the old setting or whatever the cpu wrote meanwhile
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fast_active_ff <= 1'b0;
         cfg_changed_ff <= 1'b0;
      end else begin
         if (accept) begin
            fast_active_ff <= 1'b1;
         end else if (hold_done) begin
            fast_active_ff <= 1'b0;
         end
         if (cfg_wr && (fast_active_ff || accept)) begin
            cfg_changed_ff <= 1'b1;
         end else if (accept) begin
            cfg_changed_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         MODE_RUN: begin
            if (link.sleep_req && !link.deep_sleep_select) begin
               nxt_mode = MODE_SLEEP;
            end else if (link.sleep_req) begin
               case (pmode_cfg_ff)
                  DSL_STOP:     nxt_mode = MODE_STOP;
                  DSL_STANDBY:  nxt_mode = MODE_STANDBY;
                  DSL_SHUTDOWN: nxt_mode = MODE_SHUTDOWN;
                  default:      nxt_mode = MODE_STOP;
               endcase
            end
         end
         MODE_SLEEP, MODE_STOP: begin
            if (req_s2_ff[RQ_IRQ]) begin
               nxt_mode = MODE_RUN;
            end
         end
         MODE_STANDBY: begin
            if (req_s2_ff[RQ_IRQ] || (gated_stby &&
                (req_s2_ff[RQ_TIM_A] || req_s2_ff[RQ_TIM_B]))) begin
               nxt_mode = MODE_RUN;
            end
         end
         MODE_SHUTDOWN: nxt_mode = MODE_SHUTDOWN;
         default:       nxt_mode = MODE_RUN;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_ff <= MODE_RUN;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // deferred policy bits sampled only at deep sleep entry
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         osc_off_stop_act_ff <= 1'b0;
         gate_stby_act_ff    <= 1'b0;
         low_freq_act_ff     <= 1'b0;
      end else if (mode_ff == MODE_RUN && link.sleep_req &&
                   link.deep_sleep_select) begin
         osc_off_stop_act_ff <= osc_cfg_ff[OSC_OFF_STOP_BIT];
         gate_stby_act_ff    <= mclk_cfg_ff[GATE_STBY_BIT];
         low_freq_act_ff     <= osc_cfg_ff[OSC_LOW_FREQ_BIT];
      end
   end

   // clock tree controls, registered so the link sees clean levels
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         link.osc_en       <= 1'b1;
         link.osc_base     <= 1'b1;
         link.mclk_on_osc  <= 1'b1;
         link.cpu_clk_en   <= 1'b1;
         link.bus_clk_en   <= 1'b1;
         link.lf_clk_en    <= 1'b1;
         link.timer_clk_en <= 1'b1;
         link.mid_freq_clock_en     <= 1'b0;
         link.fast_active  <= 1'b0;
         link.mode         <= MODE_RUN;
      end else begin
         if (fast_active_ff) begin
            link.osc_en      <= 1'b1;
            link.osc_base    <= 1'b1;
            link.mclk_on_osc <= 1'b1;
            link.bus_clk_en  <= 1'b1;
         end else begin
            // disable and slow select are live, not deferred
            link.osc_en <= !osc_cfg_ff[OSC_DISABLE_BIT] &&
               !(mode_ff == MODE_STOP && osc_off_stop_act_ff) &&
               mode_ff != MODE_STANDBY && mode_ff != MODE_SHUTDOWN;
            link.osc_base <= is_deep(mode_ff) ? !low_freq_act_ff :
                             !osc_cfg_ff[OSC_LOW_FREQ_BIT];
            link.mclk_on_osc <= !mclk_cfg_ff[SLOW_CLK_SEL_BIT] &&
               mode_ff != MODE_STANDBY && mode_ff != MODE_SHUTDOWN;
            link.bus_clk_en <= !gated_stby &&
                               mode_ff != MODE_SHUTDOWN;
         end
         link.cpu_clk_en   <= mode_ff == MODE_RUN;
         link.lf_clk_en    <= !gated_stby && mode_ff != MODE_SHUTDOWN;
         link.timer_clk_en <= mode_ff != MODE_SHUTDOWN;
         link.mid_freq_clock_en     <= mclk_cfg_ff[MID_FREQ_CLOCK_USE_BIT] &&
            (fast_active_ff || !is_deep(mode_ff));
         link.fast_active  <= fast_active_ff;
         link.mode         <= mode_ff;
      end
   end
endmodule
